//--- design/cso_ctrl_map.svh
// Register offsets, field positions and reset values of the sensing control block
`ifndef CSO_CTRL_MAP_SVH
`define CSO_CTRL_MAP_SVH

// ----------------------------------------------------------------
// Word indices on the register bus
// ----------------------------------------------------------------
`define CSO_IDX_CONTROL0 4'h0
`define CSO_IDX_CONTROL1 4'h1
`define CSO_IDX_TIMER_CTRL 4'h2
`define CSO_IDX_TIMER1_COUNT 4'h3

// ----------------------------------------------------------------
// Control register 0 fields
// ----------------------------------------------------------------
`define CSO_BIT_ENABLE 7
`define CSO_BIT_REF_MODE 6
`define CSO_RANGE_HI 3
`define CSO_RANGE_LO 2
`define CSO_BIT_DIR_STATUS 1
`define CSO_BIT_T0_EXT_SEL 0

// ----------------------------------------------------------------
// Control register 1 and timer control fields
// ----------------------------------------------------------------
`define CSO_CHAN_HI 3
`define CSO_CHAN_LO 0
`define CSO_BIT_T0_CS 0
`define CSO_BIT_T1_ON 1
`define CSO_BIT_T1_GATE_EN 2
`define CSO_T1CS_HI 5
`define CSO_T1CS_LO 4

// ----------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------
`define CSO_RANGE_OFF 2'h0
`define CSO_RANGE_LOW 2'h1
`define CSO_RANGE_MED 2'h2
`define CSO_RANGE_HIGH 2'h3
`define CSO_T1CS_SENSE 2'h3
`define CSO_CHAN_LAST_SMALL 4'h3
`define CSO_CHAN_LAST_LARGE 4'h7
`define CSO_CHAN_ALIAS_FIRST 4'h8
`define CSO_CHAN_ALIAS_LAST 4'hB
`define CSO_CHAN_ALIAS_OFFSET 4'h4
`define CSO_RESET_BYTE 8'h00
`define CSO_RESET_CHAN 4'h0
`define CSO_COUNT_HI 15
`define CSO_COUNT_LO 0
`define CSO_RESET_COUNT 16'h0000
`define CSO_COUNT_ONE 16'h0001
`define CSO_PIN_NONE 8'h00
`define CSO_PIN_ONE 8'h01

`endif

//--- design/cso_ctrl_pkg.sv
// Types shared by the sensing control block
package cso_ctrl_pkg;

  typedef enum logic [7:0] {
    CSO_MODE_OFF = 8'h01,
    CSO_MODE_NOISE = 8'h02,
    CSO_MODE_FIX_LOW = 8'h04,
    CSO_MODE_FIX_MED = 8'h08,
    CSO_MODE_FIX_HIGH = 8'h10,
    CSO_MODE_VAR_LOW = 8'h20,
    CSO_MODE_VAR_MED = 8'h40,
    CSO_MODE_VAR_HIGH = 8'h80
  } cso_power_mode_type;

  typedef enum logic [2:0] {
    CSO_T0_CORE = 3'h1,
    CSO_T0_PIN = 3'h2,
    CSO_T0_SENSE = 3'h4
  } cso_t0_source_type;

endpackage

//--- design/cso_sync.sv
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
`default_nettype none

module cso_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // cso_sync

`default_nettype wire

//--- design/cso_ctrl.sv
// Control logic around the capacitive sensing relaxation oscillator
//
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cso_ctrl_map.svh"

module cso_ctrl #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  input wire logic [3:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  input wire logic OSC_COMPARATOR_IN,
  input wire logic TIMER1_GATE_IN,
  output logic [7:0] SENSE_PIN_CONNECT_OUT,
  output logic OSC_RUN_OUT,
  output logic CURRENT_DRIVE_OUT,
  output logic VARIABLE_REF_OUT,
  output logic [1:0] CURRENT_LEVEL_OUT,
  output logic [7:0] POWER_MODE_OUT,
  output logic [2:0] TIMER0_SOURCE_OUT,
  output logic TIMER0_SENSE_CLOCK_OUT,
  output logic TIMER1_SENSE_CLOCK_OUT,
  output logic TIMER1_COUNT_ENABLE_OUT
);

  // ----------------------------------------------------------------
  // Software-visible state
  // ----------------------------------------------------------------
  logic sensing_block_enable;
  logic reference_mode_select;
  logic [1:0] current_range_select;
  logic timer0_external_source_select;
  logic [3:0] channel_select;
  logic timer0_clock_source_select;
  logic timer1_on;
  logic timer1_gate_enable;
  logic [1:0] timer1_clock_source_select;
  logic [15:0] timer1_count;

  // ----------------------------------------------------------------
  // Bus handshake: one wait state per access
  // ----------------------------------------------------------------
  logic request;
  logic ack;
  logic wr_take;
  logic rd_take;
  logic [31:0] next_readdata;

  assign request = AVS_READ_IN | AVS_WRITE_IN;
  assign AVS_WAITREQUEST_OUT = request & ~ack;
  assign wr_take = AVS_WRITE_IN & ack;
  assign rd_take = AVS_READ_IN & ~ack;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      ack <= 1'b0;
    end else begin
      ack <= request & ~ack;
    end
  end

  // ----------------------------------------------------------------
  // Synchronised oscillator and gate levels
  // ----------------------------------------------------------------
  logic [1:0] async_levels;
  logic [1:0] sync_levels;
  logic osc_level;
  logic gate_level;
  logic osc_level_prev;
  logic osc_rise;

  assign async_levels = {TIMER1_GATE_IN, OSC_COMPARATOR_IN};

  cso_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_in(SYS_CLK_IN),
    .reset_in(RESET_IN),
    .async_in(async_levels),
    .sync_out(sync_levels)
  );

  assign osc_level = sync_levels[0];
  assign gate_level = sync_levels[1];

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      osc_level_prev <= 1'b0;
    end else begin
      osc_level_prev <= osc_level;
    end
  end

  assign osc_rise = osc_level & ~osc_level_prev;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      sensing_block_enable <= 1'b0;
      reference_mode_select <= 1'b0;
      current_range_select <= `CSO_RANGE_OFF;
      timer0_external_source_select <= 1'b0;
    end else if (wr_take && AVS_ADDRESS_IN == `CSO_IDX_CONTROL0 && AVS_BYTEENABLE_IN[0]) begin
      sensing_block_enable <= AVS_WRITEDATA_IN[`CSO_BIT_ENABLE];
      reference_mode_select <= AVS_WRITEDATA_IN[`CSO_BIT_REF_MODE];
      current_range_select <= AVS_WRITEDATA_IN[`CSO_RANGE_HI:`CSO_RANGE_LO];
      timer0_external_source_select <= AVS_WRITEDATA_IN[`CSO_BIT_T0_EXT_SEL];
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      channel_select <= `CSO_RESET_CHAN;
    end else if (wr_take && AVS_ADDRESS_IN == `CSO_IDX_CONTROL1 && AVS_BYTEENABLE_IN[0]) begin
      channel_select <= AVS_WRITEDATA_IN[`CSO_CHAN_HI:`CSO_CHAN_LO];
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      timer0_clock_source_select <= 1'b0;
      timer1_on <= 1'b0;
      timer1_gate_enable <= 1'b0;
      timer1_clock_source_select <= `CSO_RANGE_OFF;
    end else if (wr_take && AVS_ADDRESS_IN == `CSO_IDX_TIMER_CTRL && AVS_BYTEENABLE_IN[0]) begin
      timer0_clock_source_select <= AVS_WRITEDATA_IN[`CSO_BIT_T0_CS];
      timer1_on <= AVS_WRITEDATA_IN[`CSO_BIT_T1_ON];
      timer1_gate_enable <= AVS_WRITEDATA_IN[`CSO_BIT_T1_GATE_EN];
      timer1_clock_source_select <= AVS_WRITEDATA_IN[`CSO_T1CS_HI:`CSO_T1CS_LO];
    end
  end

  // ----------------------------------------------------------------
  // Power mode decode
  // ----------------------------------------------------------------
  cso_ctrl_pkg::cso_power_mode_type next_mode;

  always_comb begin
    next_mode = cso_ctrl_pkg::CSO_MODE_OFF;
    if (sensing_block_enable) begin
      case ({reference_mode_select, current_range_select})
        3'h0: next_mode = cso_ctrl_pkg::CSO_MODE_OFF;
        3'h1: next_mode = cso_ctrl_pkg::CSO_MODE_FIX_LOW;
        3'h2: next_mode = cso_ctrl_pkg::CSO_MODE_FIX_MED;
        3'h3: next_mode = cso_ctrl_pkg::CSO_MODE_FIX_HIGH;
        3'h4: next_mode = cso_ctrl_pkg::CSO_MODE_NOISE;
        3'h5: next_mode = cso_ctrl_pkg::CSO_MODE_VAR_LOW;
        3'h6: next_mode = cso_ctrl_pkg::CSO_MODE_VAR_MED;
        3'h7: next_mode = cso_ctrl_pkg::CSO_MODE_VAR_HIGH;
        default: next_mode = cso_ctrl_pkg::CSO_MODE_OFF;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      POWER_MODE_OUT <= cso_ctrl_pkg::CSO_MODE_OFF;
      OSC_RUN_OUT <= 1'b0;
      CURRENT_DRIVE_OUT <= 1'b0;
      VARIABLE_REF_OUT <= 1'b0;
      CURRENT_LEVEL_OUT <= `CSO_RANGE_OFF;
    end else begin
      POWER_MODE_OUT <= next_mode;
      // Noise mode keeps the comparator alive with no pin current
      OSC_RUN_OUT <= (next_mode != cso_ctrl_pkg::CSO_MODE_OFF);
      CURRENT_DRIVE_OUT <= (next_mode != cso_ctrl_pkg::CSO_MODE_OFF) &&
                           (next_mode != cso_ctrl_pkg::CSO_MODE_NOISE);
      VARIABLE_REF_OUT <= sensing_block_enable & reference_mode_select;
      CURRENT_LEVEL_OUT <= sensing_block_enable ? current_range_select : `CSO_RANGE_OFF;
    end
  end

  // ----------------------------------------------------------------
  // Channel multiplexer
  // ----------------------------------------------------------------
  logic [7:0] next_pins;
  logic [3:0] chan_last;

  assign chan_last = LARGE_VARIANT ? `CSO_CHAN_LAST_LARGE : `CSO_CHAN_LAST_SMALL;

  // Reserved and unimplemented codes leave every pin free, never two at once
  always_comb begin
    next_pins = `CSO_PIN_NONE;
    if (sensing_block_enable) begin
      if (channel_select <= chan_last) begin
        next_pins = `CSO_PIN_ONE << channel_select[2:0];
      end else if (LARGE_VARIANT && channel_select >= `CSO_CHAN_ALIAS_FIRST &&
                   channel_select <= `CSO_CHAN_ALIAS_LAST) begin
        next_pins = `CSO_PIN_ONE << 3'(channel_select - `CSO_CHAN_ALIAS_OFFSET);
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      SENSE_PIN_CONNECT_OUT <= `CSO_PIN_NONE;
    end else begin
      SENSE_PIN_CONNECT_OUT <= next_pins;
    end
  end

  // ----------------------------------------------------------------
  // Timer clock routing
  // ----------------------------------------------------------------
  logic osc_active;
  logic t1_sense_sel;
  logic t1_enable;

  assign osc_active = (next_mode != cso_ctrl_pkg::CSO_MODE_OFF);
  assign t1_sense_sel = (timer1_clock_source_select == `CSO_T1CS_SENSE);
  // Off without the on bit; with gate enable the gate level decides
  assign t1_enable = timer1_on & (~timer1_gate_enable | gate_level);

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      TIMER0_SOURCE_OUT <= cso_ctrl_pkg::CSO_T0_CORE;
    end else if (!timer0_clock_source_select) begin
      TIMER0_SOURCE_OUT <= cso_ctrl_pkg::CSO_T0_CORE;
    end else if (timer0_external_source_select) begin
      TIMER0_SOURCE_OUT <= cso_ctrl_pkg::CSO_T0_SENSE;
    end else begin
      TIMER0_SOURCE_OUT <= cso_ctrl_pkg::CSO_T0_PIN;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      TIMER0_SENSE_CLOCK_OUT <= 1'b0;
      TIMER1_SENSE_CLOCK_OUT <= 1'b0;
      TIMER1_COUNT_ENABLE_OUT <= 1'b0;
    end else begin
      TIMER0_SENSE_CLOCK_OUT <= osc_active & osc_level & timer0_clock_source_select &
                                timer0_external_source_select;
      TIMER1_SENSE_CLOCK_OUT <= osc_active & osc_level & t1_sense_sel;
      TIMER1_COUNT_ENABLE_OUT <= t1_enable;
    end
  end

  // Counting a clear cycle's edge keeps that oscillation in the new total
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      timer1_count <= `CSO_RESET_COUNT;
    end else if (wr_take && AVS_ADDRESS_IN == `CSO_IDX_TIMER1_COUNT) begin
      timer1_count <= (osc_rise && osc_active && t1_sense_sel && t1_enable) ?
                      `CSO_COUNT_ONE : `CSO_RESET_COUNT;
    end else if (osc_rise && osc_active && t1_sense_sel && t1_enable) begin
      timer1_count <= timer1_count + `CSO_COUNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (AVS_ADDRESS_IN)
      `CSO_IDX_CONTROL0: begin
        next_readdata[`CSO_BIT_ENABLE] = sensing_block_enable;
        next_readdata[`CSO_BIT_REF_MODE] = reference_mode_select;
        next_readdata[`CSO_RANGE_HI:`CSO_RANGE_LO] = current_range_select;
        next_readdata[`CSO_BIT_DIR_STATUS] = osc_active & osc_level;
        next_readdata[`CSO_BIT_T0_EXT_SEL] = timer0_external_source_select;
      end
      `CSO_IDX_CONTROL1: begin
        next_readdata[`CSO_CHAN_HI:`CSO_CHAN_LO] = channel_select;
      end
      `CSO_IDX_TIMER_CTRL: begin
        next_readdata[`CSO_BIT_T0_CS] = timer0_clock_source_select;
        next_readdata[`CSO_BIT_T1_ON] = timer1_on;
        next_readdata[`CSO_BIT_T1_GATE_EN] = timer1_gate_enable;
        next_readdata[`CSO_T1CS_HI:`CSO_T1CS_LO] = timer1_clock_source_select;
      end
      `CSO_IDX_TIMER1_COUNT: begin
        next_readdata[`CSO_COUNT_HI:`CSO_COUNT_LO] = timer1_count;
      end
      default: begin
        next_readdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      AVS_READDATA_OUT <= 32'h0000_0000;
    end else if (rd_take) begin
      AVS_READDATA_OUT <= next_readdata;
    end
  end

endmodule // cso_ctrl

`default_nettype wire

//--- verif/cso_sense_far_side.sv
// Far-side model: oscillator comparator source and a Timer1 style edge counter
`timescale 1ns/1ps
`default_nettype none
module cso_sense_far_side #(
  parameter int HALF = 5
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire logic [7:0] toggles_in,
  input wire logic sense_clock_in,
  input wire logic count_enable_in,
  output logic osc_out,
  output logic busy_out,
  output logic [15:0] count_out
);
  int left;
  int tick;
  logic last_clock;
  // Comparator level only moves inside a burst; it is a held level otherwise
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      osc_out <= 1'b0;
      left <= 0;
      tick <= HALF;
    end else if (go_in) begin
      left <= int'(toggles_in);
      tick <= HALF;
    end else if (left != 0) begin
      tick <= (tick == 1) ? HALF : tick - 1;
      if (tick == 1) begin
        osc_out <= ~osc_out;
        left <= left - 1;
      end
    end
  end
  assign busy_out = (left != 0);
  // Counts rising edges of the routed clock while counting is allowed
  always_ff @(posedge clk_in) begin
    last_clock <= sense_clock_in;
    if (rst_in) begin
      count_out <= 16'h0000;
    end else if (sense_clock_in && !last_clock && count_enable_in) begin
      count_out <= count_out + 16'h0001;
    end
  end
endmodule // cso_sense_far_side
`default_nettype wire

//--- verif/cso_ctrl_sva.sv
// Checker of the sensing control block ports
`timescale 1ns/1ps
`default_nettype none
module cso_ctrl_sva (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic AVS_WAITREQUEST_OUT,
  input wire logic [7:0] SENSE_PIN_CONNECT_OUT,
  input wire logic OSC_RUN_OUT,
  input wire logic CURRENT_DRIVE_OUT,
  input wire logic VARIABLE_REF_OUT,
  input wire logic [1:0] CURRENT_LEVEL_OUT,
  input wire logic [7:0] POWER_MODE_OUT,
  input wire logic [2:0] TIMER0_SOURCE_OUT,
  input wire logic TIMER0_SENSE_CLOCK_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);
  logic req;
  assign req = AVS_READ_IN | AVS_WRITE_IN;
  one_wait_a: assert property (req && !$past(req) |->
    AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT)
    else $error("wait state count wrong");
  read_hold_a: assert property (!$past(AVS_READ_IN) |-> $stable(AVS_READDATA_OUT))
    else $error("read data moved without a read");
  pin_single_a: assert property ($onehot0(SENSE_PIN_CONNECT_OUT))
    else $error("more than one pin connected");
  mode_single_a: assert property ($onehot(POWER_MODE_OUT))
    else $error("power mode not one-hot");
  ref_select_a: assert property (VARIABLE_REF_OUT ==
    (|POWER_MODE_OUT[7:5] || POWER_MODE_OUT[1]))
    else $error("reference select disagrees with mode");
  noise_mode_a: assert property (POWER_MODE_OUT[1] |-> OSC_RUN_OUT && !CURRENT_DRIVE_OUT)
    else $error("noise mode drive wrong");
  off_quiet_a: assert property (POWER_MODE_OUT[0] |->
    !OSC_RUN_OUT && CURRENT_LEVEL_OUT == 2'h0)
    else $error("off mode still running");
  drive_level_a: assert property (CURRENT_DRIVE_OUT |-> CURRENT_LEVEL_OUT != 2'h0)
    else $error("drive on with zero range");
  t0_route_a: assert property (TIMER0_SENSE_CLOCK_OUT |->
    TIMER0_SOURCE_OUT[2] || $past(TIMER0_SOURCE_OUT[2]))
    else $error("timer0 clock leaks without routing");
  cover property (POWER_MODE_OUT[1]);
  cover property (CURRENT_DRIVE_OUT && VARIABLE_REF_OUT);
  cover property (SENSE_PIN_CONNECT_OUT[7]);
endmodule // cso_ctrl_sva
bind cso_ctrl cso_ctrl_sva u_sva (.SYS_CLK_IN(SYS_CLK_IN), .RESET_IN(RESET_IN),
  .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
  .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .SENSE_PIN_CONNECT_OUT(SENSE_PIN_CONNECT_OUT),
  .OSC_RUN_OUT(OSC_RUN_OUT), .CURRENT_DRIVE_OUT(CURRENT_DRIVE_OUT),
  .VARIABLE_REF_OUT(VARIABLE_REF_OUT), .CURRENT_LEVEL_OUT(CURRENT_LEVEL_OUT),
  .POWER_MODE_OUT(POWER_MODE_OUT), .TIMER0_SOURCE_OUT(TIMER0_SOURCE_OUT),
  .TIMER0_SENSE_CLOCK_OUT(TIMER0_SENSE_CLOCK_OUT));
`default_nettype wire

//--- verif/tb_cso_ctrl.sv
// Self-checking testbench of the sensing control block
`timescale 1ns/1ps
`default_nettype none
module tb_cso_ctrl;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, gate = 1'b0, go = 1'b0;
  logic [3:0] addr = 4'h0, be = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [7:0] toggles = 8'h00, pins, pmode;
  logic [2:0] t0src;
  logic [1:0] level;
  logic [15:0] pcount, base;
  logic waitreq, osc, run, drive, vref, t0clk, t1clk, t1en, busy;
  int n_fail = 0, comparisons = 0;
  cso_ctrl DUT (.SYS_CLK_IN(clk), .RESET_IN(rst), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata),
    .AVS_WAITREQUEST_OUT(waitreq), .OSC_COMPARATOR_IN(osc), .TIMER1_GATE_IN(gate),
    .SENSE_PIN_CONNECT_OUT(pins), .OSC_RUN_OUT(run), .CURRENT_DRIVE_OUT(drive),
    .VARIABLE_REF_OUT(vref), .CURRENT_LEVEL_OUT(level), .POWER_MODE_OUT(pmode),
    .TIMER0_SOURCE_OUT(t0src), .TIMER0_SENSE_CLOCK_OUT(t0clk), .TIMER1_SENSE_CLOCK_OUT(t1clk),
    .TIMER1_COUNT_ENABLE_OUT(t1en));
  cso_sense_far_side #(.HALF(5)) u_far (.clk_in(clk), .rst_in(rst), .go_in(go),
    .toggles_in(toggles), .sense_clock_in(t1clk), .count_enable_in(t1en), .osc_out(osc),
    .busy_out(busy), .count_out(pcount));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    #1;
    while (waitreq !== 1'b0 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Runs a comparator burst of the given toggle count and waits for the sync path
  task automatic burst(input logic [7:0] t);
    int n;
    n = 0;
    @(posedge clk);
    toggles <= t;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    // Busy is looked at after the edge, once the model has loaded the burst
    #1;
    while (busy !== 1'b0 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 500) begin
      n_fail++;
      report_and_stop();
    end
    settle(8);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_and_refusals();
    chk(pmode, 32'h01);
    chk(t0src, 32'h1);
    chk(pins, 32'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, i[3:0], 32'h0);
      chk(q, 32'h0);
    end
    bus(1'b1, 4'hC, 32'hFF);
    bus(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0);
    be <= 4'h0;
    bus(1'b1, 4'h0, 32'hC4);
    be <= 4'hF;
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0);
  endtask
  task automatic power_modes();
    logic [7:0] exp;
    for (int rm = 0; rm < 2; rm++) begin
      for (int rng = 0; rng < 4; rng++) begin
        bus(1'b1, 4'h0, 32'h80 | (rm << 6) | (rng << 2));
        settle(3);
        exp = (rm == 1) ? ((rng == 0) ? 8'h02 : 8'h10 << rng) :
              ((rng == 0) ? 8'h01 : 8'h02 << rng);
        chk(pmode, exp);
        chk(vref, rm);
        chk(drive, rng != 0);
        chk(run, rm == 1 || rng != 0);
        chk(level, rng);
        bus(1'b0, 4'h0, 32'h0);
        chk(q, 32'h80 | (rm << 6) | (rng << 2));
      end
    end
    bus(1'b1, 4'h0, 32'h4C);
    settle(3);
    chk(pmode, 32'h01);
    chk(level, 32'h0);
  endtask
  task automatic channels();
    logic [7:0] exp;
    bus(1'b1, 4'h0, 32'h84);
    for (int ch = 0; ch < 16; ch++) begin
      bus(1'b1, 4'h1, ch);
      settle(3);
      exp = (ch < 8) ? 8'h01 << ch : (ch < 12) ? 8'h01 << (ch - 4) : 8'h00;
      chk(pins, exp);
      bus(1'b0, 4'h1, 32'h0);
      chk(q, ch);
    end
    bus(1'b1, 4'h1, 32'h2);
    bus(1'b1, 4'h0, 32'h04);
    settle(3);
    chk(pins, 32'h0);
    bus(1'b1, 4'h0, 32'h84);
    settle(3);
    chk(pins, 32'h04);
  endtask
  task automatic direction_status();
    burst(8'h01);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h86);
    burst(8'h01);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h84);
  endtask
  // Count only while the sensing clock routes to Timer1 and counting is allowed
  task automatic timer1_count(input logic [7:0] ctrl, input logic g, input logic [15:0] exp);
    gate <= g;
    bus(1'b1, 4'h2, ctrl);
    bus(1'b1, 4'h3, 32'h0);
    base = pcount;
    burst(8'h0A);
    bus(1'b0, 4'h3, 32'h0);
    chk(q[15:0], exp);
    chk(pcount - base, exp);
  endtask
  task automatic timer0_route();
    bus(1'b1, 4'h2, 32'h01);
    bus(1'b1, 4'h0, 32'h85);
    settle(3);
    chk(t0src, 32'h4);
    burst(8'h01);
    chk(t0clk, 32'h1);
    bus(1'b1, 4'h0, 32'h84);
    settle(3);
    chk(t0src, 32'h2);
    chk(t0clk, 32'h0);
    bus(1'b1, 4'h2, 32'h00);
    settle(3);
    chk(t0src, 32'h1);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    reset_and_refusals();
    power_modes();
    channels();
    direction_status();
    timer1_count(8'h32, 1'b0, 16'h0005);
    timer1_count(8'h36, 1'b0, 16'h0000);
    timer1_count(8'h36, 1'b1, 16'h0005);
    timer1_count(8'h30, 1'b1, 16'h0000);
    timer0_route();
    report_and_stop();
  end
endmodule // tb_cso_ctrl
`default_nettype wire
